/* File: hw/ata_register_access_engine_regs.svh */
// Purpose: Register map, field layout and timing figures of the register access engine
// Assumes: Byte-wide microcontroller data space, 20 MHz system clock
// Notes: Definitions only
`ifndef ATA_REGISTER_ACCESS_ENGINE_REGS_SVH
`define ATA_REGISTER_ACCESS_ENGINE_REGS_SVH

// Data space offsets
`define ADDR_HOLDING_LOW 16'hf0d2
`define ADDR_HOLDING_HIGH 16'hf0d3
`define ADDR_BUS_ACCESS_CONTROL 16'hf0d4
`define ADDR_SECTOR_COUNTDOWN_LOW 16'hf0d5
`define ADDR_BYTE_TOTAL_1 16'hf0d7
`define ADDR_BYTE_TOTAL_2 16'hf0d8

// Fields of bus_access_control
`define SELECT_MSB 7
`define SELECT_LSB 4
`define WRITE_STROBE_BIT 3
`define READ_STROBE_BIT 2
`define FLUSH_BIT 1
`define SECTORS_MSB_BIT 0
`define SELECT_BLOCK_BIT 3
`define SELECT_DATA_REG 4'h8

// Transfer byte total bits 15:9 sit in byte 1, bits 17:16 in byte 2
`define TOTAL1_SECTOR_MSB 7
`define TOTAL1_SECTOR_LSB 1
`define TOTAL2_SECTOR_MSB 1
`define TOTAL2_SECTOR_LSB 0

// Reset values
`define RESET_SELECT 4'h0
`define RESET_WORD 16'h0000
`define RESET_SECTORS 9'h000
`define ZERO_BYTE 8'h00

// Register cycle timing
`define CLOCK_PERIOD_NS 50
`define T_ADDR_SETUP_NS 70
`define T_STROBE_NARROW_NS 290
`define T_STROBE_WIDE_NS 165
`define T_DATA_HOLD_NS 20
`define T_RECOVER_NS 70
`define NS_TO_CYC(ns) (((ns) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ADDR_SETUP_CYC `NS_TO_CYC(`T_ADDR_SETUP_NS)
`define STROBE_NARROW_CYC `NS_TO_CYC(`T_STROBE_NARROW_NS)
`define STROBE_WIDE_CYC `NS_TO_CYC(`T_STROBE_WIDE_NS)
`define DATA_HOLD_CYC `NS_TO_CYC(`T_DATA_HOLD_NS)
`define RECOVER_CYC `NS_TO_CYC(`T_RECOVER_NS)

`endif

/* File: hw/ata_access_pkg.sv */
// Purpose: Types shared by the register access engine
// Assumes: Nothing
// Notes: Timing and offsets live in the register header
package ata_access_pkg;

	typedef enum logic [2:0] {
		CYCLE_IDLE = 3'b000,
		CYCLE_SETUP = 3'b001,
		CYCLE_STROBE = 3'b010,
		CYCLE_HOLD = 3'b011,
		CYCLE_RECOVER = 3'b100
	} cycle_state_type;

endpackage

/* File: hw/sector_countdown.sv */
// Purpose: Nine-bit sector countdown for PIO data transfers
// Assumes: One pulse of sector_done per 512-byte sector moved
// Notes: Load beats decrement in the same cycle
`timescale 1ns/10ps
`include "ata_register_access_engine_regs.svh"

module sector_countdown (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [8:0] load_value,
	input wire logic sector_done,
	output logic [8:0] sectors_left
);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sectors_left <= `RESET_SECTORS;
		end else if (load) begin
			sectors_left <= load_value;
		end else if (sector_done && (sectors_left != `RESET_SECTORS)) begin
			// Stops at zero so an extra pulse cannot wrap around
			sectors_left <= sectors_left - 9'h001;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_count_load: assert property (load |=> sectors_left == $past(load_value))
		else $error("sector countdown did not take the loaded value");

	a_count_step: assert property ((!load && sector_done && sectors_left != `RESET_SECTORS)
		|=> sectors_left == $past(sectors_left) - 9'h001)
		else $error("sector countdown did not step down by one");

	a_count_hold: assert property ((!load && !sector_done) |=> $stable(sectors_left))
		else $error("sector countdown moved without a sector");

endmodule // sector_countdown

/* File: hw/ata_register_access_engine.sv */
// Purpose: Firmware-driven register cycles to an ATA/ATAPI device, buffer flush, sector countdown
// Assumes: Byte-wide data space port, single-cycle read and write requests, synchronous pins
// Notes: Read data appear on mcu_rdata one cycle after mcu_read
`timescale 1ns/10ps
`include "ata_register_access_engine_regs.svh"

module ata_register_access_engine (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] mcu_addr,
	input wire logic [7:0] mcu_wdata,
	input wire logic mcu_write,
	input wire logic mcu_read,
	output logic [7:0] mcu_rdata,
	input wire logic sector_done,
	output logic sector_buffer_flush,
	output logic command_block_select_n,
	output logic control_block_select_n,
	output logic [2:0] device_address,
	output logic device_read_n,
	output logic device_write_n,
	input wire logic [15:0] device_data_in,
	output logic [15:0] device_data_out,
	output logic device_data_oe_n
);

	logic [3:0] bus_register_select;
	logic bus_read_strobe;
	logic bus_write_strobe;
	logic [15:0] access_holding_word;
	logic [8:0] sectors_left;
	logic [8:0] byte_total_sector_bits;
	logic [8:0] next_byte_total_sector_bits;
	logic total_load;
	ata_access_pkg::cycle_state_type state;
	ata_access_pkg::cycle_state_type next_state;
	logic [3:0] phase_count;
	logic [3:0] next_phase_count;
	logic phase_done;
	logic cycle_done;
	logic launch;
	logic cycle_is_read;
	logic cycle_is_wide;
	logic [3:0] cycle_select;
	logic [3:0] next_select;
	logic next_is_read;
	logic next_is_wide;
	logic next_active;
	logic read_capture;
	logic control_write;

	assign control_write = mcu_write && (mcu_addr == `ADDR_BUS_ACCESS_CONTROL);
	assign phase_done = (phase_count == 4'h0);
	assign launch = (state == ata_access_pkg::CYCLE_IDLE) && (bus_read_strobe || bus_write_strobe);
	assign cycle_done = (state == ata_access_pkg::CYCLE_RECOVER) && phase_done;
	assign read_capture = (state == ata_access_pkg::CYCLE_STROBE) && phase_done && cycle_is_read;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_register_select <= `RESET_SELECT;
		end else if (control_write) begin
			bus_register_select <= mcu_wdata[`SELECT_MSB:`SELECT_LSB];
		end
	end

	// read strobe self-clear
	// Firmware setting a strobe in the completion cycle wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_read_strobe <= 1'b0;
		end else if (control_write && mcu_wdata[`READ_STROBE_BIT]) begin
			bus_read_strobe <= 1'b1;
		end else if (cycle_done) begin
			bus_read_strobe <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_write_strobe <= 1'b0;
		end else if (control_write && mcu_wdata[`WRITE_STROBE_BIT]) begin
			bus_write_strobe <= 1'b1;
		end else if (cycle_done) begin
			bus_write_strobe <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sector_buffer_flush <= 1'b0;
		end else begin
			sector_buffer_flush <= control_write && mcu_wdata[`FLUSH_BIT];
		end
	end

	// read data capture, narrow reads zero the high byte
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			access_holding_word <= `RESET_WORD;
		end else if (read_capture) begin
			access_holding_word <= cycle_is_wide ? device_data_in : {`ZERO_BYTE, device_data_in[7:0]};
		end else if (mcu_write && (mcu_addr == `ADDR_HOLDING_LOW)) begin
			access_holding_word[7:0] <= mcu_wdata;
		end else if (mcu_write && (mcu_addr == `ADDR_HOLDING_HIGH)) begin
			access_holding_word[15:8] <= mcu_wdata;
		end
	end

	// shadow of byte total bits 17:9
	always_comb begin
		next_byte_total_sector_bits = byte_total_sector_bits;
		total_load = 1'b0;
		if (mcu_write && (mcu_addr == `ADDR_BYTE_TOTAL_1)) begin
			next_byte_total_sector_bits[6:0] = mcu_wdata[`TOTAL1_SECTOR_MSB:`TOTAL1_SECTOR_LSB];
			total_load = 1'b1;
		end
		if (mcu_write && (mcu_addr == `ADDR_BYTE_TOTAL_2)) begin
			next_byte_total_sector_bits[8:7] = mcu_wdata[`TOTAL2_SECTOR_MSB:`TOTAL2_SECTOR_LSB];
			total_load = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			byte_total_sector_bits <= `RESET_SECTORS;
		end else begin
			byte_total_sector_bits <= next_byte_total_sector_bits;
		end
	end

	sector_countdown countdown (
		.clock(clock),
		.rst_n(rst_n),
		.load(total_load),
		.load_value(next_byte_total_sector_bits),
		.sector_done(sector_done),
		.sectors_left(sectors_left)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mcu_rdata <= `ZERO_BYTE;
		end else if (mcu_read) begin
			unique case (mcu_addr)
				`ADDR_HOLDING_LOW: mcu_rdata <= access_holding_word[7:0];
				`ADDR_HOLDING_HIGH: mcu_rdata <= access_holding_word[15:8];
				`ADDR_BUS_ACCESS_CONTROL: mcu_rdata <= {bus_register_select, bus_write_strobe,
					bus_read_strobe, sector_buffer_flush, sectors_left[8]};
				`ADDR_SECTOR_COUNTDOWN_LOW: mcu_rdata <= sectors_left[7:0];
				default: mcu_rdata <= `ZERO_BYTE;
			endcase
		end
	end

	// read wins, width, no address filtering
	assign next_select = (state == ata_access_pkg::CYCLE_IDLE) ? bus_register_select : cycle_select;
	assign next_is_read = (state == ata_access_pkg::CYCLE_IDLE) ? bus_read_strobe : cycle_is_read;
	assign next_is_wide = (next_select == `SELECT_DATA_REG);
	assign next_active = (next_state != ata_access_pkg::CYCLE_IDLE);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cycle_select <= `RESET_SELECT;
			cycle_is_read <= 1'b0;
			cycle_is_wide <= 1'b0;
		end else if (launch) begin
			cycle_select <= next_select;
			cycle_is_read <= next_is_read;
			cycle_is_wide <= next_is_wide;
		end
	end

	always_comb begin
		next_state = state;
		next_phase_count = phase_done ? 4'h0 : phase_count - 4'h1;
		unique case (state)
			ata_access_pkg::CYCLE_IDLE: begin
				if (launch) begin
					next_state = ata_access_pkg::CYCLE_SETUP;
					next_phase_count = 4'(`ADDR_SETUP_CYC - 1);
				end
			end
			ata_access_pkg::CYCLE_SETUP: begin
				if (phase_done) begin
					next_state = ata_access_pkg::CYCLE_STROBE;
					next_phase_count = cycle_is_wide ? 4'(`STROBE_WIDE_CYC - 1) : 4'(`STROBE_NARROW_CYC - 1);
				end
			end
			ata_access_pkg::CYCLE_STROBE: begin
				if (phase_done) begin
					next_state = ata_access_pkg::CYCLE_HOLD;
					next_phase_count = 4'(`DATA_HOLD_CYC - 1);
				end
			end
			ata_access_pkg::CYCLE_HOLD: begin
				if (phase_done) begin
					next_state = ata_access_pkg::CYCLE_RECOVER;
					next_phase_count = 4'(`RECOVER_CYC - 1);
				end
			end
			ata_access_pkg::CYCLE_RECOVER: begin
				if (phase_done) begin
					next_state = ata_access_pkg::CYCLE_IDLE;
				end
			end
			default: begin
				next_state = ata_access_pkg::CYCLE_IDLE;
				next_phase_count = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ata_access_pkg::CYCLE_IDLE;
			phase_count <= 4'h0;
		end else begin
			state <= next_state;
			phase_count <= next_phase_count;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			command_block_select_n <= 1'b1;
			control_block_select_n <= 1'b1;
			device_address <= 3'h0;
		end else begin
			command_block_select_n <= !(next_active && next_select[`SELECT_BLOCK_BIT]);
			control_block_select_n <= !(next_active && !next_select[`SELECT_BLOCK_BIT]);
			device_address <= next_active ? next_select[2:0] : 3'h0;
		end
	end

	// strobes and write data drive, data held through hold phase
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			device_read_n <= 1'b1;
			device_write_n <= 1'b1;
			device_data_oe_n <= 1'b1;
			device_data_out <= `RESET_WORD;
		end else begin
			device_read_n <= !((next_state == ata_access_pkg::CYCLE_STROBE) && next_is_read);
			device_write_n <= !((next_state == ata_access_pkg::CYCLE_STROBE) && !next_is_read);
			device_data_oe_n <= !(next_active && !next_is_read && (next_state != ata_access_pkg::CYCLE_RECOVER));
			if (launch) begin
				device_data_out <= access_holding_word;
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence flush_request;
		control_write && mcu_wdata[`FLUSH_BIT];
	endsequence

	sequence read_launch;
		launch && bus_read_strobe;
	endsequence

	a_flush_pulse: assert property (flush_request |=> sector_buffer_flush)
		else $error("flush did not pulse after being written");

	a_flush_clears: assert property ((sector_buffer_flush && !(control_write && mcu_wdata[`FLUSH_BIT])) |=> !sector_buffer_flush)
		else $error("flush bit stayed set beyond one cycle");

	a_read_start: assert property (read_launch |=> (state == ata_access_pkg::CYCLE_SETUP)
		&& cycle_is_read ##[1:12] !device_read_n)
		else $error("read strobe did not start a read cycle");

	a_read_wins: assert property ((read_launch and bus_write_strobe) |=> device_write_n [*8])
		else $error("write ran although read was also requested");

	a_strobes_clear: assert property ((cycle_done && !control_write) |=> !bus_read_strobe && !bus_write_strobe)
		else $error("strobes not cleared at cycle end");

	a_read_stored: assert property (read_capture |=> access_holding_word == ($past(cycle_is_wide)
		? $past(device_data_in) : {`ZERO_BYTE, $past(device_data_in[7:0])}))
		else $error("read data not stored in holding word");

	a_write_data: assert property ((launch && !bus_read_strobe)
		|=> device_data_out == $past(access_holding_word))
		else $error("write cycle not driving data");

	a_write_drive: assert property ($rose(device_write_n) && !$past(device_write_n) |-> !device_data_oe_n)
		else $error("write data released at strobe trailing edge");

	a_block_select: assert property (!device_read_n || !device_write_n |->
		command_block_select_n == !cycle_select[`SELECT_BLOCK_BIT]
		&& control_block_select_n == cycle_select[`SELECT_BLOCK_BIT])
		else $error("wrong block select during strobe");

	a_data_width: assert property ((read_capture && cycle_select != `SELECT_DATA_REG)
		|=> access_holding_word[15:8] == `ZERO_BYTE)
		else $error("cycle width does not match register");

	a_any_address: assert property (launch |=> !command_block_select_n || !control_block_select_n)
		else $error("access not run on the bus");

	a_setup_first: assert property (($fell(device_read_n) || $fell(device_write_n))
		|-> !$past(command_block_select_n) || !$past(control_block_select_n))
		else $error("strobe asserted without select setup");

	a_cycle_ends: assert property (launch |-> ##[9:11] cycle_done)
		else $error("register cycle length out of range");

	a_reset_zero: assert property ($rose(rst_n) |-> bus_register_select == `RESET_SELECT
		&& !bus_read_strobe && !bus_write_strobe && !sector_buffer_flush && sectors_left == `RESET_SECTORS)
		else $error("control fields not zero after reset");

endmodule // ata_register_access_engine

/* File: dv/ata_device_model.sv */
// Purpose: Behavioural storage device on the register side of the parallel bus
// Assumes: Synchronous pins, one register per select value
// Notes: Released data lines toggle so stale values never look valid
`timescale 1ns/10ps

module ata_device_model (
	input wire logic clock,
	input wire logic cmd_sel_n,
	input wire logic ctl_sel_n,
	input wire logic [2:0] addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [15:0] dout,
	input wire logic oe_n,
	output logic [15:0] din
);
	logic [15:0] mem [16];
	logic [15:0] drv = 16'h0000;
	logic [3:0] key;
	logic picked;
	assign key = {~cmd_sel_n, addr};
	assign picked = ~cmd_sel_n | ~ctl_sel_n;
	// Capture under strobe with selects held
	always @(posedge clock) begin
		if (!wr_n && !oe_n && picked)
			mem[key] <= dout;
		drv <= (!rd_n && picked) ? mem[key] : ~drv;
	end
	assign din = drv;
endmodule // ata_device_model

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the register access engine
// Assumes: Device model on the parallel bus side
// Notes: Inputs change on the falling edge only
`timescale 1ns/10ps
`include "ata_register_access_engine_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end

module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] mcu_addr = 16'h0000;
	logic [7:0] mcu_wdata = 8'h00;
	logic mcu_write = 1'b0;
	logic mcu_read = 1'b0;
	logic sector_done = 1'b0;
	logic [7:0] mcu_rdata;
	logic flush;
	logic cmd_sel_n, ctl_sel_n, rd_n, wr_n, oe_n;
	logic [2:0] dev_addr;
	logic [15:0] din, dout;
	int err_count = 0;
	int total_checks = 0;
	int flush_seen = 0;
	int wr_falls = 0;
	logic [15:0] pat [16];

	always #25 clock = ~clock;
	always @(negedge clock) if (flush === 1'b1) flush_seen++;
	always @(negedge wr_n) wr_falls++;

	ata_register_access_engine dut (.clock(clock), .rst_n(rst_n), .mcu_addr(mcu_addr),
		.mcu_wdata(mcu_wdata), .mcu_write(mcu_write), .mcu_read(mcu_read), .mcu_rdata(mcu_rdata),
		.sector_done(sector_done), .sector_buffer_flush(flush), .command_block_select_n(cmd_sel_n),
		.control_block_select_n(ctl_sel_n), .device_address(dev_addr), .device_read_n(rd_n),
		.device_write_n(wr_n), .device_data_in(din), .device_data_out(dout), .device_data_oe_n(oe_n));
	ata_device_model model (.clock(clock), .cmd_sel_n(cmd_sel_n), .ctl_sel_n(ctl_sel_n),
		.addr(dev_addr), .rd_n(rd_n), .wr_n(wr_n), .dout(dout), .oe_n(oe_n), .din(din));

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		mcu_addr = a;
		mcu_wdata = d;
		mcu_write = 1'b1;
		@(negedge clock);
		mcu_write = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clock);
		mcu_addr = a;
		mcu_read = 1'b1;
		@(negedge clock);
		mcu_read = 1'b0;
		d = mcu_rdata;
	endtask

	task automatic hold_word(input logic [15:0] w);
		wr(`ADDR_HOLDING_LOW, w[7:0]);
		wr(`ADDR_HOLDING_HIGH, w[15:8]);
	endtask

	// Launch one bus cycle, check pins mid-cycle, wait for self-clear
	task automatic cyc(input logic [3:0] s, input logic [3:0] lo);
		logic [7:0] v;
		int n;
		wr(`ADDR_BUS_ACCESS_CONTROL, {s, lo});
		n = 0;
		while (rd_n !== 1'b0 && wr_n !== 1'b0 && n < 40) begin
			@(negedge clock);
			n++;
		end
		`CHK("strobe seen", 1'b1, n < 40)
		`CHK("command select", ~s[3], cmd_sel_n)
		`CHK("control select", s[3], ctl_sel_n)
		`CHK("address", s[2:0], dev_addr)
		rd(`ADDR_BUS_ACCESS_CONTROL, v);
		`CHK("busy bit", 1'b1, lo[2] ? v[2] : v[3])
		// Wait until both strobes have cleared
		n = 0;
		do begin
			rd(`ADDR_BUS_ACCESS_CONTROL, v);
			n++;
		end while (v[3:2] !== 2'b00 && n < 40);
		`CHK("strobes cleared", 2'b00, v[3:2])
		`CHK("select kept", s, v[7:4])
	endtask

	task automatic t_reset;
		logic [7:0] v;
		rd(`ADDR_BUS_ACCESS_CONTROL, v);
		`CHK("control reset", 8'h00, v)
		rd(`ADDR_SECTOR_COUNTDOWN_LOW, v);
		`CHK("countdown reset", 8'h00, v)
		$display("test reset done");
	endtask

	task automatic t_writes;
		// Reserved places are visited on purpose here
		for (int s = 0; s < 16; s++) begin
			pat[s] = {4'h9, 4'(s), 4'h6, 4'(s)};
			hold_word(pat[s]);
			cyc(4'(s), 4'b1000);
			`CHK("stored low", pat[s][7:0], model.mem[s][7:0])
			if (s == 8)
				`CHK("stored wide", pat[s], model.mem[s])
		end
		$display("test writes done");
	endtask

	task automatic t_reads;
		logic [7:0] v;
		for (int s = 0; s < 16; s++) begin
			hold_word(16'hffff);
			cyc(4'(s), 4'b0100);
			rd(`ADDR_HOLDING_LOW, v);
			`CHK("read low", pat[s][7:0], v)
			rd(`ADDR_HOLDING_HIGH, v);
			`CHK("read high", (s == 8) ? pat[s][15:8] : 8'h00, v)
		end
		$display("test reads done");
	endtask

	task automatic t_both;
		logic [7:0] v;
		int f;
		hold_word(16'h1234);
		f = wr_falls;
		cyc(4'h9, 4'b1100);
		`CHK("write dropped", f, wr_falls)
		`CHK("device kept", pat[9], model.mem[9])
		rd(`ADDR_HOLDING_LOW, v);
		`CHK("read done", pat[9][7:0], v)
		$display("test both strobes done");
	endtask

	task automatic t_flush;
		logic [7:0] v;
		flush_seen = 0;
		wr(`ADDR_BUS_ACCESS_CONTROL, 8'h02);
		repeat (4) @(negedge clock);
		`CHK("flush pulses", 1, flush_seen)
		rd(`ADDR_BUS_ACCESS_CONTROL, v);
		`CHK("flush cleared", 1'b0, v[1])
		$display("test flush done");
	endtask

	task automatic pulses(input int n);
		@(negedge clock);
		sector_done = 1'b1;
		repeat (n) @(negedge clock);
		sector_done = 1'b0;
	endtask

	task automatic t_count;
		logic [7:0] v;
		logic [7:0] c;
		// Expected sectors placed in total bits 17:9
		wr(`ADDR_BYTE_TOTAL_2, 8'h03);
		wr(`ADDR_BYTE_TOTAL_1, 8'h5a);
		rd(`ADDR_SECTOR_COUNTDOWN_LOW, v);
		`CHK("seed low", 8'had, v)
		rd(`ADDR_BUS_ACCESS_CONTROL, c);
		`CHK("seed msb", 1'b1, c[0])
		pulses(9'h0ae);
		rd(`ADDR_SECTOR_COUNTDOWN_LOW, v);
		rd(`ADDR_BUS_ACCESS_CONTROL, c);
		`CHK("after sectors", 9'h0ff, {c[0], v})
		wr(`ADDR_SECTOR_COUNTDOWN_LOW, 8'h55);
		rd(`ADDR_SECTOR_COUNTDOWN_LOW, v);
		`CHK("read only", 8'hff, v)
		pulses(9'h100);
		rd(`ADDR_SECTOR_COUNTDOWN_LOW, v);
		rd(`ADDR_BUS_ACCESS_CONTROL, c);
		`CHK("floor zero", 9'h000, {c[0], v})
		rd(16'hf0e0, v);
		`CHK("unmapped", 8'h00, v)
		$display("test countdown done");
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_writes();
		t_reads();
		t_both();
		t_flush();
		t_count();
		results();
	end

	// Whole run is near 1170 cycles; allow about seventeen times that
	initial begin
		#1000000;
		err_count++;
		results();
	end
endmodule // testbench
